/* rtl/omm_defines.vh */
/*
 * constants of the optical module management port: bus addresses,
 * map geometry, timing counts and reset values.
 * assumes a 40 MHz core clock; included by bare name.
 */
`ifndef OMM_DEFINES_VH
`define OMM_DEFINES_VH

`define OMM_CLK_MHZ           40
`define OMM_ID_ADDR7          7'h50
`define OMM_DIAG_ADDR7        7'h51
`define OMM_MAP_DEPTH         256
`define OMM_DIAG_VAL_BASE     8'h60
`define OMM_DIAG_VAL_END      8'h69
`define OMM_DIAG_FLAG_BASE    8'h70
`define OMM_DIAG_FLAG_END     8'h7F
`define OMM_DIAG_USER_BASE    8'h80
`define OMM_TXDIS_US          10
`define OMM_TXDIS_CYC         ((`OMM_TXDIS_US * `OMM_CLK_MHZ) - 2)
`define OMM_PTR_RST           8'h00
`define OMM_SDA_RELEASE       1'b1

`endif

/* rtl/omm_mgmt_port.v */
/*
 * management port of a pluggable optical module: two-wire slave serving an
 * identification map and a diagnostics map, receive-signal-absent output,
 * transmit-disable handling. assumes core_clk at 40 MHz, far faster than
 * the host's serial clock; the identification map is loaded by software-free
 * ports (id_wr_*) at manufacture and is read-only on the serial bus.
 */
// Functional notes
// - rx_signal_absent is 0 while light is present and 1 when none is detected.
// - while light is present the recovered receive data appears on the differential outputs.
// - a high or floating transmit-disable input turns the laser off, a low keeps it on.
// - the laser is off no later than 10 us after transmit-disable is raised.
// - the identification map of 256 bytes answers at bus address A0h.
// - the diagnostics map answers at A2h and leaves the identification map untouched.
// - the identification map holds capability, interface and maker data the host can read.
// - write data is taken on serial clock rising edges and stored only where not protected.
// - read data changes on serial clock falling edges.
// - the data line is two-way and transactions are framed by start and stop conditions.
// - both maps are byte wide and reached singly or with an auto-incrementing pointer.
// - temperature, bias, tx power, rx power and supply are sampled continuously.
// - one alarm flag per value is raised when that value leaves its configured range.
// - values are reported as already calibrated, with no host step needed.
`timescale 1ns/1ps
`include "omm_defines.vh"
module omm_mgmt_port (
    input  wire        core_clk,
    input  wire        arst_n,
    input  wire        scl_in,
    input  wire        sda_in,
    output reg         sda_out,
    output reg         sda_oe_n,
    input  wire        tx_disable_in,
    output reg         laser_enable,
    input  wire        rx_light_detect,
    input  wire        rx_data_in,
    output reg         rx_data_p,
    output reg         rx_data_n,
    output reg         rx_signal_absent,
    input  wire [79:0] diag_values,
    input  wire [79:0] diag_hi_lim,
    input  wire [79:0] diag_lo_lim,
    input  wire        id_wr_en,
    input  wire [7:0]  id_wr_addr,
    input  wire [7:0]  id_wr_data
);
    reg        rst_s1_reg;
    reg        rst_s2_reg;
    wire       rst_n;
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_s1_reg <= 1'b0;
            rst_s2_reg <= 1'b0;
        end else begin
            rst_s1_reg <= 1'b1;
            rst_s2_reg <= rst_s1_reg;
        end
    end
    assign rst_n = rst_s2_reg;

    // idle levels at reset: no false scl edge, and the laser stays dark
    wire [4:0] pin_s;
    omm_sync2 #(.W(5), .RST_VAL(5'h1C)) u_sync (
        .clk   (core_clk),
        .rst_n (rst_n),
        .d     ({scl_in, sda_in, tx_disable_in, rx_light_detect, rx_data_in}),
        .q     (pin_s)
    );
    wire scl_s   = pin_s[4];
    wire sda_s   = pin_s[3];
    wire txdis_s = pin_s[2];
    wire light_s = pin_s[1];
    wire data_s  = pin_s[0];

    reg  scl_d_reg;
    reg  sda_d_reg;
    wire scl_rise = scl_s & ~scl_d_reg;
    wire scl_fall = ~scl_s & scl_d_reg;
    wire start_c  = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
    wire stop_c   = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

    // receive path and loss of signal
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_signal_absent <= 1'b1;
            rx_data_p        <= 1'b0;
            rx_data_n        <= 1'b0;
        end else begin
            rx_signal_absent <= ~light_s;
            rx_data_p        <= light_s & data_s;
            rx_data_n        <= light_s & ~data_s;
        end
    end

    // transmit disable: pull-up makes a floating pin read high
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            laser_enable <= 1'b0;
        end else if (!txdis_s) begin
            laser_enable <= 1'b1;
        end else begin
            laser_enable <= 1'b0;
        end
    end

    // maps
    reg  [7:0] id_mem [0:`OMM_MAP_DEPTH-1];
    reg  [7:0] diag_user [0:127];
    reg  [7:0] diag_flags_reg [0:1];
    wire [7:0] alarm_w;
    genvar g;
    generate
        for (g = 0; g < 5; g = g + 1) begin : g_mon
            wire [15:0] v = diag_values[16*g+15:16*g];
            assign alarm_w[g] = (v > diag_hi_lim[16*g+15:16*g]) |
                                (v < diag_lo_lim[16*g+15:16*g]);
        end
    endgenerate
    assign alarm_w[7:5] = 3'b000;

    always @(posedge core_clk) begin
        if (id_wr_en)
            id_mem[id_wr_addr] <= id_wr_data;
    end

    // flags at 70h sticky until read, 71h live; a new excursion wins over the read clear
    reg       flag_rd_clr;
    reg [7:0] ptr_reg;
    reg       dev_sel_reg;
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            diag_flags_reg[0] <= 8'h00;
            diag_flags_reg[1] <= 8'h00;
        end else begin
            diag_flags_reg[0] <= alarm_w | (flag_rd_clr ? 8'h00 : diag_flags_reg[0]);
            diag_flags_reg[1] <= alarm_w;
        end
    end

    // serial slave
    localparam ST_IDLE = 6'b000001;
    localparam ST_ADDR = 6'b000010;
    localparam ST_PTR  = 6'b000100;
    localparam ST_WR   = 6'b001000;
    localparam ST_RD   = 6'b010000;
    localparam ST_ACK  = 6'b100000;

    reg [5:0] st_reg;
    reg [5:0] ret_reg;
    reg [7:0] sh_reg;
    reg [3:0] bit_reg;
    reg       ack_phase_reg;
    reg [7:0] rd_byte;
    reg [7:0] wr_byte;

    always @* begin
        rd_byte = 8'h00;
        if (!dev_sel_reg)
            rd_byte = id_mem[ptr_reg];
        else if (ptr_reg[7])
            rd_byte = diag_user[ptr_reg[6:0]];
        else if (ptr_reg == `OMM_DIAG_FLAG_BASE || ptr_reg == `OMM_DIAG_FLAG_BASE + 8'h01)
            rd_byte = diag_flags_reg[ptr_reg[0]];
        else if (ptr_reg >= `OMM_DIAG_VAL_BASE && ptr_reg <= `OMM_DIAG_VAL_END)
            rd_byte = ptr_reg[0] ? diag_values[{ptr_reg[3:1], 4'h0} +: 8]
                                 : diag_values[{ptr_reg[3:1], 4'h8} +: 8];
    end

    always @* begin
        wr_byte = {sh_reg[6:0], sda_s};
    end

    always @(posedge core_clk) begin
        if (st_reg == ST_WR && scl_rise && bit_reg == 4'h7 && dev_sel_reg && ptr_reg[7])
            diag_user[ptr_reg[6:0]] <= wr_byte;
    end

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg        <= ST_IDLE;
            ret_reg       <= ST_IDLE;
            sh_reg        <= 8'h00;
            bit_reg       <= 4'h0;
            ack_phase_reg <= 1'b0;
            ptr_reg       <= `OMM_PTR_RST;
            dev_sel_reg   <= 1'b0;
            sda_out       <= 1'b0;
            sda_oe_n      <= `OMM_SDA_RELEASE;
            scl_d_reg     <= 1'b1;
            sda_d_reg     <= 1'b1;
            flag_rd_clr   <= 1'b0;
        end else begin
            scl_d_reg   <= scl_s;
            sda_d_reg   <= sda_s;
            flag_rd_clr <= 1'b0;
            if (stop_c) begin
                st_reg   <= ST_IDLE;
                sda_oe_n <= `OMM_SDA_RELEASE;
            end else if (start_c) begin
                st_reg   <= ST_ADDR;
                bit_reg  <= 4'h0;
                sda_oe_n <= `OMM_SDA_RELEASE;
            end else begin
                case (st_reg)
                ST_IDLE: begin
                    sda_oe_n <= `OMM_SDA_RELEASE;
                end
                ST_ADDR, ST_PTR, ST_WR: begin
                    if (scl_rise) begin
                        sh_reg  <= wr_byte;
                        bit_reg <= bit_reg + 4'h1;
                    end
                    if (scl_fall && bit_reg == 4'h8) begin
                        bit_reg <= 4'h0;
                        if (st_reg == ST_ADDR) begin
                            if (sh_reg[7:1] == `OMM_ID_ADDR7 ||
                                sh_reg[7:1] == `OMM_DIAG_ADDR7) begin
                                dev_sel_reg <= sh_reg[1];
                                sda_oe_n    <= 1'b0;
                                ret_reg     <= sh_reg[0] ? ST_RD : ST_PTR;
                                st_reg      <= ST_ACK;
                            end else begin
                                st_reg <= ST_IDLE;
                            end
                        end else begin
                            if (st_reg == ST_PTR)
                                ptr_reg <= sh_reg;
                            else
                                ptr_reg <= ptr_reg + 8'h01;
                            sda_oe_n <= 1'b0;
                            ret_reg  <= ST_WR;
                            st_reg   <= ST_ACK;
                        end
                        sda_out       <= 1'b0;
                        ack_phase_reg <= 1'b0;
                    end
                end
                ST_ACK: begin
                    if (scl_fall) begin
                        st_reg  <= ret_reg;
                        bit_reg <= 4'h0;
                        if (ret_reg == ST_RD) begin
                            sda_out  <= 1'b0;
                            sda_oe_n <= rd_byte[7];
                            sh_reg   <= {rd_byte[6:0], 1'b0};
                            bit_reg  <= 4'h1;
                            flag_rd_clr <= dev_sel_reg && ptr_reg == `OMM_DIAG_FLAG_BASE;
                            ptr_reg  <= ptr_reg + 8'h01;
                        end else begin
                            sda_oe_n <= `OMM_SDA_RELEASE;
                        end
                    end
                end
                ST_RD: begin
                    if (scl_rise && ack_phase_reg) begin
                        if (sda_s)
                            st_reg <= ST_IDLE;
                        ack_phase_reg <= 1'b0;
                    end else if (scl_fall) begin
                        if (ack_phase_reg) begin
                            sda_oe_n <= `OMM_SDA_RELEASE;
                        end else if (bit_reg == 4'h8) begin
                            sda_oe_n      <= `OMM_SDA_RELEASE;
                            ack_phase_reg <= 1'b1;
                            bit_reg       <= 4'h0;
                        end else if (bit_reg == 4'h0) begin
                            sda_oe_n <= rd_byte[7];
                            sh_reg   <= {rd_byte[6:0], 1'b0};
                            bit_reg  <= 4'h1;
                            flag_rd_clr <= dev_sel_reg && ptr_reg == `OMM_DIAG_FLAG_BASE;
                            ptr_reg  <= ptr_reg + 8'h01;
                        end else begin
                            sda_oe_n <= sh_reg[7];
                            sh_reg   <= {sh_reg[6:0], 1'b0};
                            bit_reg  <= bit_reg + 4'h1;
                        end
                    end
                end
                default: begin
                    st_reg <= ST_IDLE;
                end
                endcase
            end
        end
    end
endmodule // omm_mgmt_port

/* rtl/omm_sync2.v */
/*
 * two-flop synchroniser, one per bit via a generate loop.
 * assumes async inputs; first stage feeds only the second.
 * reset level per bit comes from RST_VAL, so idle-high pins show no edge.
 */
`timescale 1ns/1ps
module omm_sync2 #(
    parameter         W       = 1,
    parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
    input  wire         clk,
    input  wire         rst_n,
    input  wire [W-1:0] d,
    output wire [W-1:0] q
);
    genvar i;
    generate
        for (i = 0; i < W; i = i + 1) begin : g_bit
            reg s1_reg;
            reg s2_reg;
            always @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    s1_reg <= RST_VAL[i];
                    s2_reg <= RST_VAL[i];
                end else begin
                    s1_reg <= d[i];
                    s2_reg <= s1_reg;
                end
            end
            assign q[i] = s2_reg;
        end
    endgenerate
endmodule // omm_sync2

/* verif/omm_host_model.sv */
/* two-wire bus master standing in for the host board.
   assumes a pull-up on the data line; q sets the pace in clk cycles. */
`timescale 1ns/1ps
module omm_host_model (
    input  wire logic clk,
    input  wire logic sda,
    output logic      scl,
    output logic      sda_drv
);
    integer q = 2;
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end
    task wt;
        repeat (q) @(negedge clk);
    endtask
    // clock only runs inside frames, host is its only source
    task bit_io(input logic b, output logic s);
        wt;
        sda_drv = b;
        wt;
        scl = 1'b1;
        wt;
        s = sda;
        wt;
        scl = 1'b0;
    endtask
    task start;
        wt;
        sda_drv = 1'b1;
        wt;
        scl = 1'b1;
        wt;
        sda_drv = 1'b0;
        wt;
        scl = 1'b0;
    endtask
    task stop;
        wt;
        sda_drv = 1'b0;
        wt;
        scl = 1'b1;
        wt;
        sda_drv = 1'b1;
        wt;
    endtask
    task byte_io(input logic [7:0] d, input logic ab, output logic [7:0] r, output logic k);
        for (int j = 7; j >= 0; j--)
            bit_io(d[j], r[j]);
        bit_io(ab, k);
    endtask
endmodule // omm_host_model

/* verif/omm_mgmt_port_assertions.sv */
/* pin-level checker for omm_mgmt_port, attached by bind.
   assumes scl low phases of at least four core clocks. */
`timescale 1ns/1ps
module omm_mgmt_port_assertions (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic scl_in,
    input wire logic sda_out,
    input wire logic sda_oe_n,
    input wire logic tx_disable_in,
    input wire logic laser_enable,
    input wire logic rx_light_detect,
    input wire logic rx_data_in,
    input wire logic rx_data_p,
    input wire logic rx_data_n,
    input wire logic rx_signal_absent
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    AST_ABSENT_SET: assert property ((!rx_light_detect)[*8] |-> rx_signal_absent)
        else $error("loss flag low without light");
    AST_ABSENT_CLR: assert property (rx_light_detect[*8] |-> !rx_signal_absent)
        else $error("loss flag high with light");
    AST_RX_MUTE: assert property ((!rx_light_detect)[*8] |-> !rx_data_p && !rx_data_n)
        else $error("receive pair active without light");
    AST_RX_PASS: assert property ((rx_light_detect && rx_data_in)[*8] |-> rx_data_p && !rx_data_n)
        else $error("receive pair not following data");
    AST_TX_OFF: assert property (tx_disable_in[*4] |-> !laser_enable)
        else $error("laser still on after disable");
    AST_TX_ON: assert property ((!tx_disable_in)[*8] |-> laser_enable)
        else $error("laser off while enabled");
    AST_SDA_LOW: assert property (!sda_oe_n |-> !sda_out)
        else $error("data line driven high");
    AST_SDA_EDGE: assert property ($changed(sda_oe_n) |-> !scl_in && !$past(scl_in))
        else $error("data line changed outside clock low");
    cover property ($fell(sda_oe_n));
    cover property ($fell(laser_enable));
    cover property ($fell(rx_signal_absent));
endmodule // omm_mgmt_port_assertions

bind omm_mgmt_port omm_mgmt_port_assertions u_chk (.core_clk(core_clk), .arst_n(arst_n),
    .scl_in(scl_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .tx_disable_in(tx_disable_in),
    .laser_enable(laser_enable), .rx_light_detect(rx_light_detect), .rx_data_in(rx_data_in),
    .rx_data_p(rx_data_p), .rx_data_n(rx_data_n), .rx_signal_absent(rx_signal_absent));

/* verif/omm_mgmt_port_test.sv */
/* self-checking bench for omm_mgmt_port with a host model on the bus.
   assumes 40 MHz core clock and a pulled-up data line. */
`timescale 1ns/1ps
module omm_mgmt_port_test;
    logic        core_clk = 1'b0;
    logic        arst_n = 1'b0;
    logic        tx_disable_in = 1'b1;
    logic        rx_light_detect = 1'b0;
    logic        rx_data_in = 1'b0;
    logic        id_wr_en = 1'b0;
    logic [7:0]  id_wr_addr = 8'h00;
    logic [7:0]  id_wr_data = 8'h00;
    logic [79:0] dv = 80'h1A1B_1819_1617_1415_1213;
    logic [79:0] hi = {5{16'hFFFF}};
    logic [79:0] lo = {80{1'b0}};
    logic [7:0]  rbuf [0:15];
    logic [7:0]  r;
    logic        k;
    int          num_errors = 0;
    int          check_count = 0;
    wire         scl, host_sda, sda_out, sda_oe_n, laser_enable;
    wire         rx_data_p, rx_data_n, rx_signal_absent;
    wire         sda = host_sda & (sda_oe_n | sda_out);
    initial forever #12.5 core_clk = ~core_clk;
    omm_host_model HOST (.clk(core_clk), .sda(sda), .scl(scl), .sda_drv(host_sda));
    omm_mgmt_port DUT (.core_clk(core_clk), .arst_n(arst_n), .scl_in(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe_n(sda_oe_n), .tx_disable_in(tx_disable_in),
        .laser_enable(laser_enable), .rx_light_detect(rx_light_detect),
        .rx_data_in(rx_data_in), .rx_data_p(rx_data_p), .rx_data_n(rx_data_n),
        .rx_signal_absent(rx_signal_absent), .diag_values(dv), .diag_hi_lim(hi),
        .diag_lo_lim(lo), .id_wr_en(id_wr_en), .id_wr_addr(id_wr_addr),
        .id_wr_data(id_wr_data));
    task chk8(input logic [7:0] g, input logic [7:0] e);
        check_count++;
        if (g !== e) begin
            num_errors++;
            $display("CHECK FAILED %0t: byte %h expected %h", $time, g, e);
        end
    endtask
    task chk1(input logic g, input logic e);
        check_count++;
        if (g !== e) begin
            num_errors++;
            $display("CHECK FAILED %0t: bit %b expected %b", $time, g, e);
        end
    endtask
    task send_addr(input logic [6:0] a, input logic rw, input logic e);
        HOST.start;
        HOST.byte_io({a, rw}, 1'b1, r, k);
        chk1(k, e);
    endtask
    task wr(input logic [6:0] a, input logic [7:0] p, input logic [15:0] d, input int n);
        send_addr(a, 1'b0, 1'b0);
        HOST.byte_io(p, 1'b1, r, k);
        chk1(k, 1'b0);
        for (int j = 0; j < n; j++) begin
            HOST.byte_io(d[15-8*j -: 8], 1'b1, r, k);
            chk1(k, 1'b0);
        end
        HOST.stop;
    endtask
    task rd(input logic [6:0] a, input logic [7:0] p, input int n);
        send_addr(a, 1'b0, 1'b0);
        HOST.byte_io(p, 1'b1, r, k);
        send_addr(a, 1'b1, 1'b0);
        for (int j = 0; j < n; j++)
            HOST.byte_io(8'hFF, j == n - 1, rbuf[j], k);
        HOST.stop;
    endtask
    task complete_run;
        $display("errors %0d, checks %0d", num_errors, check_count);
        if (num_errors == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial begin
        repeat (60000) @(posedge core_clk);
        num_errors++;
        complete_run;
    end
    initial begin
        repeat (20) @(negedge core_clk);
        chk1(rx_signal_absent, 1'b1);
        chk1(sda_oe_n, 1'b1);
        arst_n = 1'b1;
        // factory load; the id map is read-only from the bus
        for (int i = 0; i < 256; i++) begin
            id_wr_en = 1'b1;
            id_wr_addr = i[7:0];
            id_wr_data = i[7:0] ^ 8'h5A;
            @(negedge core_clk);
        end
        id_wr_en = 1'b0;
        chk1(laser_enable, 1'b0);
        rd(7'h50, 8'h00, 4);
        for (int i = 0; i < 4; i++)
            chk8(rbuf[i], i[7:0] ^ 8'h5A);
        rd(7'h50, 8'hFF, 2);
        chk8(rbuf[0], 8'hA5);
        chk8(rbuf[1], 8'h5A);
        wr(7'h50, 8'h01, 16'h5500, 1);
        rd(7'h50, 8'h01, 1);
        chk8(rbuf[0], 8'h5B);
        wr(7'h51, 8'h80, 16'h3CC3, 2);
        wr(7'h51, 8'h60, 16'hEE00, 1);
        rd(7'h51, 8'h80, 2);
        chk8(rbuf[0], 8'h3C);
        chk8(rbuf[1], 8'hC3);
        rd(7'h50, 8'h80, 1);
        chk8(rbuf[0], 8'hDA);
        rd(7'h51, 8'h60, 10);
        for (int i = 0; i < 10; i++)
            chk8(rbuf[i], dv[16*(i/2) + 8*(1-i%2) +: 8]);
        rd(7'h51, 8'h6A, 1);
        chk8(rbuf[0], 8'h00);
        lo[15:0] = 16'h2000;
        hi[31:16] = 16'h1000;
        rd(7'h51, 8'h71, 1);
        chk8(rbuf[0], 8'h03);
        lo[15:0] = 16'h0000;
        hi[31:16] = 16'hFFFF;
        rd(7'h51, 8'h71, 1);
        chk8(rbuf[0], 8'h00);
        rd(7'h51, 8'h70, 1);
        chk8(rbuf[0], 8'h03);
        rd(7'h51, 8'h70, 1);
        chk8(rbuf[0], 8'h00);
        send_addr(7'h52, 1'b0, 1'b1);
        HOST.stop;
        HOST.q = 4;
        rd(7'h50, 8'h10, 1);
        chk8(rbuf[0], 8'h4A);
        HOST.q = 2;
        tx_disable_in = 1'b0;
        repeat (8) @(negedge core_clk);
        chk1(laser_enable, 1'b1);
        tx_disable_in = 1'b1;
        for (int i = 0; i < 400 && laser_enable; i++)
            @(negedge core_clk);
        chk1(laser_enable, 1'b0);
        rx_light_detect = 1'b1;
        rx_data_in = 1'b1;
        repeat (8) @(negedge core_clk);
        chk1(rx_signal_absent, 1'b0);
        chk1(rx_data_p, 1'b1);
        rx_data_in = 1'b0;
        repeat (6) @(negedge core_clk);
        chk1(rx_data_n, 1'b1);
        rx_light_detect = 1'b0;
        repeat (8) @(negedge core_clk);
        chk1(rx_signal_absent, 1'b1);
        complete_run;
    end
endmodule // omm_mgmt_port_test
